// ===== verilog/multirate_lane.sv
// Control logic of one multi-rate serial lane with APB register access
//
// Notes on behaviour
// R1: Rates 100M oversampled, 1G, 2.5G, 5G
// R2: Lane active only with lane enable
// R3: Held in reset until both resets released
// R4: PLL calibration runs only when enabled
// R5: Software: word, reset low, then reset high
// R6: Software: control word 60 or 48
// R7: Software: rotation and rate bits per speed
// R8: Equipment loopback feeds serializer into deserializer
// R9: Equipment loopback still drives line output
// R10: Facility loopback returns received data outward
// R11: Software enables one loopback at most
// R12: Both loopbacks set: equipment loopback wins
// R13: Recovered clock routed to selected outputs
// R14: Software: shared clock on one lane only
// R15: Auto squelch while PCS lacks valid data
// R16: Integrator limited below proportional path
// R17: Fast components handled by proportional path
// R18: Software: time constant within range
// R19: Lower time constant setting integrates faster
// R20: Cut-off scales with 2^(tc+1-bw)
// R21: Integrator settles toggling between neighbours
// R22: Bandwidth setting halves tracking limit per step
// R23: Lowest bandwidth gives widest tracking
// R24: Deadlock protection adds small frequency offset
`timescale 1ns/1ps
`include "lane_defines.svh"
module multirate_lane
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic      [31:0]        prdata,
	output logic                    pslverr,
	input  wire logic               tx_data_in,
	input  wire logic               rx_line_in,
	input  wire logic               phase_early,
	input  wire logic               phase_late,
	input  wire logic               pcs_data_valid,
	output logic                    line_tx_out,
	output logic                    des_data_out,
	output logic                    lane_active,
	output logic                    rec_clk_lane,
	output logic                    rec_clk_shared,
	output logic                    rec_clk_shared_oe
);
	// ****************************************************************
	// Registers and wires
	// ****************************************************************
	logic [`COM_W-1:0]          common_r;
	logic [`PLL_W-1:0]          pll_r;
	logic [`DES_W-1:0]          des_r;
	logic [`MISC_W-1:0]         misc_r;
	logic                       pready_r;
	logic [31:0]                prdata_r;
	logic                       pslverr_r;
	lane_pkg::lane_state_t      state_r;
	lane_pkg::lane_state_t      state_nxt;
	logic [`CAL_CNT_W-1:0]      cal_cnt_r;
	logic                       cal_done_r;
	logic [15:0]                phase_acc_r;
	logic                       des_in_r;
	logic                       des_data_r;
	logic                       line_tx_r;
	logic                       active_r;
	logic                       clk_lane_r;
	logic                       clk_shared_r;
	logic                       shared_oe_r;
	logic                       setup;
	logic                       wr_commit;
	logic                       hit_common;
	logic                       hit_pll;
	logic                       hit_des;
	logic                       hit_misc;
	logic                       hit_status;
	logic                       mapped;
	logic [31:0]                rd_mux;
	logic                       resets_off;
	logic                       eloop;
	logic                       floop;
	logic                       des_source;
	logic                       line_source;
	logic                       rec_clk;
	logic                       squelch_lane;
	logic                       squelch_shared;
	logic                       word_ok;
	lane_pkg::rate_t            rate;
	logic [15:0]                step_corr;
	logic [7:0]                 integ_val;

	// ****************************************************************
	// Functions
	// ****************************************************************
	// Rate from oversampling and half or quarter speed selects
	function automatic lane_pkg::rate_t rate_of(input logic [`COM_W-1:0] c);
		if (c[`COM_OVERSAMPLE])
			return lane_pkg::RATE_100M;
		else if (c[`COM_QUARTER])
			return lane_pkg::RATE_1G;
		else if (c[`COM_HALF])
			return lane_pkg::RATE_2G5;
		else
			return lane_pkg::RATE_5G;
	endfunction

	// Nominal phase increment per clock for a rate
	function automatic logic [15:0] nominal_step(input lane_pkg::rate_t r);
		case (r)
			lane_pkg::RATE_100M: return `STEP_100M;
			lane_pkg::RATE_1G:   return `STEP_1G;
			lane_pkg::RATE_2G5:  return `STEP_2G5;
			default:             return `STEP_5G;
		endcase
	endfunction

	// ****************************************************************
	// APB decode
	// ****************************************************************
	// Setup detection and commit on the answered access cycle
	assign setup      = psel && !penable;
	assign wr_commit  = psel && penable && pready_r && pwrite;
	assign hit_common = (paddr == `ADDR_COMMON);
	assign hit_pll    = (paddr == `ADDR_PLL);
	assign hit_des    = (paddr == `ADDR_DES);
	assign hit_misc   = (paddr == `ADDR_MISC);
	assign hit_status = (paddr == `ADDR_STATUS);
	assign mapped     = hit_common || hit_pll || hit_des || hit_misc || hit_status;

	// Read data selection; status shows own state
	assign word_ok = (pll_r[`PLL_WORD_MSB:`PLL_WORD_LSB] == `PLL_WORD_1G)
		|| (pll_r[`PLL_WORD_MSB:`PLL_WORD_LSB] == `PLL_WORD_2G5);
	assign rd_mux = hit_common ? 32'(common_r)
		: hit_pll  ? 32'(pll_r)
		: hit_des  ? 32'(des_r)
		: hit_misc ? 32'(misc_r)
		: hit_status ? (32'(state_r) << `ST_STATE_LSB) | (32'(rate) << `ST_RATE_LSB)
			| (32'(cal_done_r) << `ST_CAL_DONE) | (32'(word_ok) << `ST_WORD_OK)
			| (32'(integ_val) << `ST_INTEG_LSB)
		: 32'h0000_0000;

	// Bus answer: ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r  <= setup;
			prdata_r  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
			pslverr_r <= setup && !mapped;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Writes land at the answered access edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			common_r <= `COM_RESET;
			pll_r    <= `PLL_RESET;
			des_r    <= `DES_RESET;
			misc_r   <= `MISC_RESET;
		end
		else if (wr_commit)
		begin
			if (hit_common)
				common_r <= pwdata[`COM_W-1:0];
			if (hit_pll)
				pll_r <= pwdata[`PLL_W-1:0];
			if (hit_des)
				des_r <= pwdata[`DES_W-1:0];
			if (hit_misc)
				misc_r <= pwdata[`MISC_W-1:0];
		end
	end

	// ****************************************************************
	// Lane reset and PLL calibration sequence
	// ****************************************************************
	// Both resets released (system reset is active low)
	assign resets_off = common_r[`COM_SYS_RELEASE] && !misc_r[`MISC_LANE_RST]; // [R3]
	assign rate       = rate_of(common_r); // [R1]

	// Calibration runs while enabled; lane works once calibrated
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			lane_pkg::LS_RESET:
				if (common_r[`COM_SYS_RELEASE] && pll_r[`PLL_CAL_EN])
					state_nxt = lane_pkg::LS_CAL; // [R4]
			lane_pkg::LS_CAL:
				if (!common_r[`COM_SYS_RELEASE] || !pll_r[`PLL_CAL_EN])
					state_nxt = lane_pkg::LS_RESET; // [R4]
				else if (cal_done_r)
					state_nxt = lane_pkg::LS_ACTIVE;
			lane_pkg::LS_ACTIVE:
				if (!common_r[`COM_SYS_RELEASE])
					state_nxt = lane_pkg::LS_RESET; // [R3]
			default:
				state_nxt = lane_pkg::LS_RESET;
		endcase
	end

	// Calibration timer and sequencer state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r    <= lane_pkg::LS_RESET;
			cal_cnt_r  <= '0;
			cal_done_r <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			cal_cnt_r  <= (state_r == lane_pkg::LS_CAL && !cal_done_r)
				? cal_cnt_r + 1'b1 : '0;
			cal_done_r <= (state_r == lane_pkg::LS_CAL && !cal_done_r)
				? (cal_cnt_r == `CAL_CNT_W'(`CAL_CYCLES - 1))
				: (state_r != lane_pkg::LS_RESET) && cal_done_r;
		end
	end

	// ****************************************************************
	// Loopback data path
	// ****************************************************************
	// Equipment loopback has priority over facility loopback
	assign eloop       = common_r[`COM_ELOOP];
	assign floop       = common_r[`COM_FLOOP] && !eloop; // [R12]
	assign des_source  = eloop ? tx_data_in : rx_line_in; // [R8]
	assign line_source = floop ? des_in_r : tx_data_in; // [R9] [R10]

	// ****************************************************************
	// Phase regulation and recovered clock
	// ****************************************************************
	phase_regulator u_phase_regulator
	(
		.pclk         (pclk),
		.presetn      (presetn),
		.run          (active_r),
		.early        (phase_early),
		.late         (phase_late),
		.time_const   (des_r[`DES_TC_MSB:`DES_TC_LSB]),
		.bandwidth    (des_r[`DES_BW_MSB:`DES_BW_LSB]),
		.limit_ctrl   (des_r[`DES_LIM_MSB:`DES_LIM_LSB]),
		.deadlock_ena (des_r[`DES_DEADLOCK]),
		.step_r       (step_corr),
		.integ_r      (integ_val)
	);

	// Recovered clock from phase accumulator top bit
	assign rec_clk        = phase_acc_r[15];
	assign squelch_lane   = common_r[`COM_SQ_LANE] && !pcs_data_valid; // [R15]
	assign squelch_shared = common_r[`COM_SQ_SHARED] && !pcs_data_valid; // [R15]

	// Data and clock outputs, all quiet while lane inactive
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			active_r     <= 1'b0;
			phase_acc_r  <= 16'h0000;
			des_in_r     <= 1'b0;
			des_data_r   <= 1'b0;
			line_tx_r    <= 1'b0;
			clk_lane_r   <= 1'b0;
			clk_shared_r <= 1'b0;
			shared_oe_r  <= 1'b0;
		end
		else
		begin
			active_r     <= common_r[`COM_LANE_EN] && resets_off
				&& state_r == lane_pkg::LS_ACTIVE; // [R2] [R3]
			phase_acc_r  <= active_r ? phase_acc_r + nominal_step(rate) + step_corr
				: 16'h0000;
			des_in_r     <= active_r && des_source; // [R8]
			des_data_r   <= des_in_r;
			line_tx_r    <= active_r && line_source; // [R9] [R10]
			clk_lane_r   <= active_r && common_r[`COM_SEL_LANE]
				&& !squelch_lane && rec_clk; // [R13]
			clk_shared_r <= active_r && common_r[`COM_SEL_SHARED]
				&& !squelch_shared && rec_clk; // [R13]
			shared_oe_r  <= active_r && common_r[`COM_SEL_SHARED]; // [R13]
		end
	end

	// ****************************************************************
	// Output drive
	// ****************************************************************
	assign pready            = pready_r;
	assign prdata            = prdata_r;
	assign pslverr           = pslverr_r;
	assign line_tx_out       = line_tx_r;
	assign des_data_out      = des_data_r;
	assign lane_active       = active_r;
	assign rec_clk_lane      = clk_lane_r;
	assign rec_clk_shared    = clk_shared_r;
	assign rec_clk_shared_oe = shared_oe_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_inactive_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!active_r |=> !line_tx_r && !clk_lane_r && !shared_oe_r) // [R2]
		else $error("outputs toggle while lane inactive");
	a_enable_needed: assert property (@(posedge pclk) disable iff (!presetn)
		!common_r[`COM_LANE_EN] |=> !active_r) // [R2]
		else $error("lane active without enable");
	a_reset_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(!common_r[`COM_SYS_RELEASE] || misc_r[`MISC_LANE_RST]) |=> !active_r) // [R3]
		else $error("lane active while held in reset");
	a_cal_gated: assert property (@(posedge pclk) disable iff (!presetn)
		!pll_r[`PLL_CAL_EN] && state_r != lane_pkg::LS_ACTIVE
		|=> state_r != lane_pkg::LS_CAL) // [R4]
		else $error("calibration without enable");
	a_eloop_path: assert property (@(posedge pclk) disable iff (!presetn)
		active_r && eloop ##1 active_r |-> des_in_r == $past(tx_data_in)) // [R8]
		else $error("equipment loopback path broken");
	a_eloop_line: assert property (@(posedge pclk) disable iff (!presetn)
		active_r && eloop |=> line_tx_r == $past(tx_data_in)) // [R9] [R12]
		else $error("line output lost in equipment loopback");
	a_floop_path: assert property (@(posedge pclk) disable iff (!presetn)
		active_r && floop && !eloop |=> line_tx_r == $past(des_in_r)) // [R10]
		else $error("facility loopback path broken");
	a_squelch_lane: assert property (@(posedge pclk) disable iff (!presetn)
		common_r[`COM_SQ_LANE] && !pcs_data_valid |=> !clk_lane_r) // [R15]
		else $error("lane clock not squelched");
	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready_r ##1 !pready_r || (psel && !penable))
		else $error("bus answer not one cycle after setup");
	c_cal_done: cover property (@(posedge pclk) disable iff (!presetn)
		state_r == lane_pkg::LS_CAL ##1 state_r == lane_pkg::LS_ACTIVE);
	c_eloop: cover property (@(posedge pclk) disable iff (!presetn) active_r && eloop);
	c_floop: cover property (@(posedge pclk) disable iff (!presetn) active_r && floop);
	c_squelch: cover property (@(posedge pclk) disable iff (!presetn)
		active_r && squelch_shared && shared_oe_r);
endmodule

// ===== verilog/lane_defines.svh
// Register map, field positions, reset values and timing counts of the lane
`ifndef LANE_DEFINES_SVH
`define LANE_DEFINES_SVH
// ********************************************************************
// Register byte addresses
// ********************************************************************
`define ADDR_COMMON     8'h00
`define ADDR_PLL        8'h04
`define ADDR_DES        8'h08
`define ADDR_MISC       8'h0c
`define ADDR_STATUS     8'h10
// ********************************************************************
// Common configuration fields
// ********************************************************************
`define COM_LANE_EN     0
`define COM_SYS_RELEASE 1
`define COM_ELOOP       2
`define COM_FLOOP       3
`define COM_QUARTER     4
`define COM_HALF        5
`define COM_SEL_LANE    6
`define COM_SEL_SHARED  7
`define COM_SQ_LANE     8
`define COM_SQ_SHARED   9
`define COM_OVERSAMPLE  10
`define COM_W           11
`define COM_RESET       11'h000
// ********************************************************************
// PLL configuration fields
// ********************************************************************
`define PLL_WORD_LSB    0
`define PLL_WORD_MSB    7
`define PLL_CAL_EN      8
`define PLL_SPIN_FREQ   9
`define PLL_SPIN_DIR    10
`define PLL_ROT_EN      11
`define PLL_W           12
`define PLL_RESET       12'h000
`define PLL_WORD_1G     8'h3c
`define PLL_WORD_2G5    8'h30
// ********************************************************************
// Deserializer configuration fields
// ********************************************************************
`define DES_BW_LSB      0
`define DES_BW_MSB      2
`define DES_TC_LSB      3
`define DES_TC_MSB      5
`define DES_LIM_LSB     6
`define DES_LIM_MSB     7
`define DES_DEADLOCK    8
`define DES_W           9
`define DES_RESET       9'h15b
// ********************************************************************
// Miscellaneous and status fields
// ********************************************************************
`define MISC_LANE_RST   0
`define MISC_W          1
`define MISC_RESET      1'h1
`define ST_STATE_LSB    0
`define ST_RATE_LSB     2
`define ST_CAL_DONE     4
`define ST_WORD_OK      5
`define ST_INTEG_LSB    8
// ********************************************************************
// Timing and loop constants
// ********************************************************************
`define CLK_MHZ         40
`define CAL_TIME_US     10
`define CAL_CYCLES      (`CAL_TIME_US * `CLK_MHZ)
`define CAL_CNT_W       9
`define STEP_100M       16'h0148
`define STEP_1G         16'h0ccd
`define STEP_2G5        16'h2000
`define STEP_5G         16'h4000
`define INTEG_BASE      8'h10
`define DEADLOCK_STEP   16'h0001
`endif

// ===== verilog/lane_pkg.sv
// Types shared by the lane control logic
package lane_pkg;
	typedef enum logic [1:0] {RATE_100M, RATE_1G, RATE_2G5, RATE_5G} rate_t;
	typedef enum logic [1:0] {LS_RESET, LS_CAL, LS_ACTIVE} lane_state_t;
endpackage

// ===== verilog/phase_regulator.sv
// Proportional-integral phase regulator of the deserializer
`timescale 1ns/1ps
`include "lane_defines.svh"
module phase_regulator
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               run,
	input  wire logic               early,
	input  wire logic               late,
	input  wire logic [2:0]         time_const,
	input  wire logic [2:0]         bandwidth,
	input  wire logic [1:0]         limit_ctrl,
	input  wire logic               deadlock_ena,
	output logic      [15:0]        step_r,
	output logic      [7:0]         integ_r
);
	logic signed [7:0]  integ_val_r;
	logic        [7:0]  tick_r;
	logic signed [8:0]  prop_gain;
	logic signed [7:0]  integ_lim;
	logic        [3:0]  shift;
	logic               tick_done;
	logic signed [7:0]  integ_nxt;
	logic signed [15:0] step_nxt;

	// Proportional gain halves per bandwidth step; lowest setting tracks widest
	assign prop_gain = 9'sh080 >>> bandwidth; // [R22] [R23]
	// Integrator limit kept below the proportional gain, never below zero
	assign integ_lim = (9'(`INTEG_BASE << limit_ctrl) >= prop_gain)
		? 8'(prop_gain - 9'sh001) : 8'(`INTEG_BASE << limit_ctrl); // [R16]
	// Decimation 2^(tc+1-bw): lower tc gives shorter time constant
	assign shift = ({1'b0, time_const} + 4'h1 > {1'b0, bandwidth})
		? {1'b0, time_const} + 4'h1 - {1'b0, bandwidth} : 4'h0; // [R19] [R20]
	assign tick_done = (tick_r >= 8'((9'h001 << shift) - 9'h001));
	// Integrator moves one count per decimated event, clamped; settles toggling
	// A value left outside a freshly narrowed limit is pulled back first
	assign integ_nxt = (integ_val_r > integ_lim) ? integ_lim
		: (integ_val_r < -integ_lim) ? -integ_lim
		: !(tick_done && (early ^ late)) ? integ_val_r
		: (late && integ_val_r < integ_lim) ? integ_val_r + 8'sh01
		: (early && integ_val_r > -integ_lim) ? integ_val_r - 8'sh01
		: integ_val_r; // [R21]
	// Proportional path handles each event, integral adds slow offset
	assign step_nxt = 16'(integ_val_r) + (late ? 16'(prop_gain) : 16'h0000)
		- (early ? 16'(prop_gain) : 16'h0000)
		+ (deadlock_ena ? `DEADLOCK_STEP : 16'h0000); // [R17] [R24]

	// Loop state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			integ_val_r <= 8'sh00;
			tick_r      <= 8'h00;
			step_r      <= 16'h0000;
		end
		else if (!run)
		begin
			integ_val_r <= 8'sh00;
			tick_r      <= 8'h00;
			step_r      <= 16'h0000;
		end
		else
		begin
			integ_val_r <= integ_nxt;
			if (early ^ late)
				tick_r <= tick_done ? 8'h00 : tick_r + 8'h01;
			step_r <= step_nxt;
		end
	end
	assign integ_r = integ_val_r;

	a_integ_bound: assert property (@(posedge pclk) disable iff (!presetn)
		$stable(prop_gain) |-> integ_val_r < prop_gain && integ_val_r > -prop_gain) // [R16]
		else $error("integrator exceeds proportional gain");
	a_idle_steady: assert property (@(posedge pclk) disable iff (!presetn)
		run && !early && !late && $past(run) && $stable(integ_lim)
		|=> $stable(integ_val_r)) // [R21]
		else $error("integrator moved without phase event");
endmodule

// ===== sim/link_partner.sv
// Remote link partner model: line bits and phase detector hints
`timescale 1ns/1ps
module link_partner
(
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      rx_line_in,
	output logic      phase_early,
	output logic      phase_late
);
	logic [6:0] lfsr_r;
	// Pseudo-random line pattern, new bit every cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lfsr_r <= 7'h01;
		else
			lfsr_r <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
	end
	// Detector hints never assert early and late together
	assign rx_line_in  = lfsr_r[0];
	assign phase_early = lfsr_r[3] & ~lfsr_r[5];
	assign phase_late  = lfsr_r[5] & ~lfsr_r[3];
endmodule

// ===== sim/multirate_lane_test.sv
// Self-checking bench for the lane control block
`timescale 1ns/1ps
`include "lane_defines.svh"
module multirate_lane_test;
	logic        pclk           = 1'b0;
	logic        presetn        = 1'b0;
	logic        psel           = 1'b0;
	logic        penable        = 1'b0;
	logic        pwrite         = 1'b0;
	logic [7:0]  paddr          = 8'h00;
	logic [31:0] pwdata         = 32'h0;
	logic        tx_data_in     = 1'b0;
	logic        pcs_data_valid = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, rx_line_in, phase_early, phase_late;
	logic        line_tx_out, des_data_out, lane_active;
	logic        rec_clk_lane, rec_clk_shared, rec_clk_shared_oe;
	logic [2:0]  th = 3'h0;
	logic [2:0]  rh = 3'h0;
	int          fails = 0;
	int          tests_run = 0;
	int          nl, ns;

	always #12.5 pclk = ~pclk;

	multirate_lane i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .tx_data_in(tx_data_in), .rx_line_in(rx_line_in),
		.phase_early(phase_early), .phase_late(phase_late), .pcs_data_valid(pcs_data_valid),
		.line_tx_out(line_tx_out), .des_data_out(des_data_out), .lane_active(lane_active),
		.rec_clk_lane(rec_clk_lane), .rec_clk_shared(rec_clk_shared),
		.rec_clk_shared_oe(rec_clk_shared_oe));
	link_partner i_partner (.pclk(pclk), .presetn(presetn), .rx_line_in(rx_line_in),
		.phase_early(phase_early), .phase_late(phase_late));

	// History of the serial inputs as the block samples them
	always @(posedge pclk)
	begin
		th <= {th[1:0], tx_data_in};
		rh <= {rh[1:0], rx_line_in};
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task test_done;
		$display("%0d compares, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One APB transfer, waits for pready under a bound
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1)
		begin
			fails++;
			test_done;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd & m, exp);
	endtask

	// Loopback mode m: bit 0 equipment, bit 1 facility
	task loopchk(input logic [1:0] m);
		apb(1'b1, `ADDR_COMMON, 32'h013 | {28'h0, m, 2'b00});
		repeat (3) @(posedge pclk);
		repeat (8)
		begin
			@(posedge pclk);
			tx_data_in <= ~rx_line_in;
			#1;
			check(32'(des_data_out), 32'(m[0] ? th[1] : rh[1]));
			check(32'(line_tx_out), 32'(m == 2'b10 ? rh[1] : th[0]));
		end
	endtask

	// Count edges of both recovered clocks over 80 cycles, after a settling gap
	task clk_cnt;
		logic pl, ps;
		nl = 0;
		ns = 0;
		repeat (2) @(posedge pclk);
		pl = rec_clk_lane;
		ps = rec_clk_shared;
		repeat (80)
		begin
			@(posedge pclk);
			nl += int'(pl !== rec_clk_lane);
			ns += int'(ps !== rec_clk_shared);
			pl = rec_clk_lane;
			ps = rec_clk_shared;
		end
	endtask

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`ADDR_COMMON, 32'hffffffff, 32'h0);
		rdc(`ADDR_PLL, 32'hffffffff, 32'h0);
		rdc(`ADDR_MISC, 32'hffffffff, 32'h1);
		check(32'(lane_active), 32'h0);
		rdc(8'h14, 32'hffffffff, 32'h0);
		check(32'(err), 32'h1);
		apb(1'b1, `ADDR_STATUS, 32'hffffffff);
		rdc(`ADDR_STATUS, 32'h3, 32'h0);
		$display("test reset done");
		apb(1'b1, `ADDR_PLL, 32'h43c);
		apb(1'b1, `ADDR_COMMON, 32'h013);
		repeat (20) @(posedge pclk);
		rdc(`ADDR_STATUS, 32'h3, 32'h0);
		apb(1'b1, `ADDR_COMMON, 32'h011);
		apb(1'b1, `ADDR_PLL, 32'h53c);
		apb(1'b1, `ADDR_COMMON, 32'h013);
		repeat (380) @(posedge pclk);
		rdc(`ADDR_STATUS, 32'h3, 32'h1);
		repeat (30) @(posedge pclk);
		rdc(`ADDR_STATUS, 32'h3f, 32'h36);
		check(32'(lane_active), 32'h0);
		apb(1'b1, `ADDR_MISC, 32'h0);
		repeat (3) @(posedge pclk);
		check(32'(lane_active), 32'h1);
		apb(1'b1, `ADDR_COMMON, 32'h012);
		repeat (3) @(posedge pclk);
		check(32'(lane_active), 32'h0);
		$display("test bring-up done");
		apb(1'b1, `ADDR_COMMON, 32'h403);
		rdc(`ADDR_STATUS, 32'hc, 32'h0);
		apb(1'b1, `ADDR_COMMON, 32'h023);
		rdc(`ADDR_STATUS, 32'hc, 32'h8);
		apb(1'b1, `ADDR_COMMON, 32'h003);
		rdc(`ADDR_STATUS, 32'hc, 32'hc);
		loopchk(2'b01);
		loopchk(2'b10);
		loopchk(2'b11);
		loopchk(2'b00);
		$display("test loopback done");
		apb(1'b1, `ADDR_COMMON, 32'h3d3);
		clk_cnt;
		check(32'(nl + ns), 32'h0);
		pcs_data_valid <= 1'b1;
		clk_cnt;
		check(32'(nl > 0 && ns > 0), 32'h1);
		check(32'(rec_clk_shared_oe), 32'h1);
		apb(1'b1, `ADDR_COMMON, 32'h313);
		clk_cnt;
		check(32'(nl + ns + 32'(rec_clk_shared_oe)), 32'h0);
		pcs_data_valid <= 1'b0;
		apb(1'b1, `ADDR_COMMON, 32'h0d3);
		clk_cnt;
		check(32'(nl > 0 && ns > 0), 32'h1);
		$display("test recovered clock done");
		for (int bw = 2; bw < 8; bw++)
		begin
			apb(1'b1, `ADDR_DES, 32'h168 | 32'(bw));
			rdc(`ADDR_DES, 32'h1ff, 32'h168 | 32'(bw));
		end
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check(32'(lane_active | rec_clk_shared_oe), 32'h0);
		presetn <= 1'b1;
		rdc(`ADDR_DES, 32'h1ff, 32'h15b);
		$display("test deserializer and reset done");
		test_done;
	end
endmodule
